// >>> hdl/afs_pkg.sv
package afs_pkg;
  // sizes
  localparam int NUM_AXES = 4;
  localparam int NUM_PAIRS = 2;
  localparam int HALL_BITS = 3;
  localparam int STATUS_WIDTH = 8;
  localparam int SYNC_STAGES = 2;
  // status query selectors
  localparam logic [1:0] SEL_SUPPLY = 2'h0;
  localparam logic [1:0] SEL_HALL = 2'h1;
  localparam logic [1:0] SEL_CONT_CURRENT = 2'h2;
  localparam logic [1:0] SEL_ESTOP = 2'h3;
  // field positions inside selector 0
  localparam int BIT_UNDER_VOLT = 0;
  localparam int BIT_OVER_VOLT = 1;
  localparam int BIT_OVER_TEMP = 2;
  localparam int BIT_OVER_CURR = 3;
  // field position inside selector 3
  localparam int BIT_ESTOP = 0;
  // illegal hall patterns with 120 degree phasing
  localparam logic [2:0] HALL_ALL_LOW = 3'h0;
  localparam logic [2:0] HALL_ALL_HIGH = 3'h7;
  // values after reset
  localparam logic RST_AMP_ENABLE = 1'b0;
  localparam logic RST_MOTOR_OFF = 1'b1;
  localparam logic RST_RELAY = 1'b0;
  localparam logic [7:0] RST_STATUS = 8'h00;
endpackage : afs_pkg

// >>> hdl/afs_sync_if.sv
`timescale 1ns/10ps
interface afs_sync_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport user (output raw, input synced);
  modport stage (input raw, output synced);
endinterface : afs_sync_if

// >>> hdl/afs_sync.sv
`timescale 1ns/10ps
module afs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  afs_sync_if.stage bus
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] out;
  } afs_sync_state_t;

  afs_sync_state_t state_q;
  afs_sync_state_t state_d;

  // first stage feeds only the second stage
  always_comb begin
    state_d.meta = bus.raw;
    state_d.out = state_q.meta;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign bus.synced = state_q.out;
endmodule : afs_sync

// >>> hdl/amp_fault_supervisor.sv
`timescale 1ns/10ps
// Overview of operation
// - emergency stop forces amplifier off in hardware, latched until motor-off then servo-on
// - emergency stop sets selector 3 status and starts the error handler
// - hall patterns 000 and 111 are hall errors under 120 degree phasing
// - status query takes selector 0 to 3, returns eight-bit fault value
// - selector 0 reports under-voltage, over-voltage, over-current, over-temperature
// - selector 1 gives per-axis hall errors, selector 2 continuous-limit excess
// - handler starts only if thread zero runs and holds the handler label
// - status reads have no side effects and raise no error
// - over-voltage disables only while present, no latch, no handler
// - hall error disables when off-on-error set, starts handler if present
// - amplifier disabled below 18 V, resumes by itself above it
// - under-voltage at power-up starts the handler automatically
// - disable above 94 V, re-enable only below 90 V
// - pair current over 20 A latches off until clear plus servo-on or reset
// - over-current shutdown ignores off-on-error and handler presence
// - early revisions: over 100 C disables, starts handler, self-recovers
// - later revisions: over-temperature latches until below 80 C plus servo-on
// - relay option disconnects motor leads whenever in motor-off state
// - raw hall inputs readable by a separate query
module amp_fault_supervisor #(
  parameter int NUM_AXES = afs_pkg::NUM_AXES,
  parameter int NUM_PAIRS = afs_pkg::NUM_PAIRS
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic emergency_stop_input_in,
  input wire logic supply_below_18v_in,
  input wire logic supply_above_94v_in,
  input wire logic supply_below_90v_in,
  input wire logic temp_above_100c_in,
  input wire logic temp_above_80c_in,
  input wire logic late_revision_strap_in,
  input wire logic [NUM_PAIRS-1:0] pair_over_20a_in,
  input wire logic [afs_pkg::HALL_BITS*NUM_AXES-1:0] hall_in,
  input wire logic [NUM_AXES-1:0] over_continuous_in,
  input wire logic [NUM_AXES-1:0] brush_mode_in,
  input wire logic [NUM_AXES-1:0] phasing_60_in,
  input wire logic [NUM_AXES-1:0] off_on_error_in,
  input wire logic solid_state_relay_option_in,
  input wire logic motor_off_command_in,
  input wire logic servo_on_command_in,
  input wire logic controller_reset_command_in,
  input wire logic thread0_running_in,
  input wire logic handler_label_present_in,
  input wire logic amp_status_query_in,
  input wire logic [1:0] status_select_in,
  input wire logic hall_state_query_in,
  output logic amp_enable_out,
  output logic motor_off_state_out,
  output logic relay_connect_out,
  output logic amp_error_handler_out,
  output logic [afs_pkg::STATUS_WIDTH-1:0] status_data_out,
  output logic status_valid_out,
  output logic [afs_pkg::HALL_BITS*NUM_AXES-1:0] hall_state_out,
  output logic hall_state_valid_out
);
  localparam int HW = afs_pkg::HALL_BITS * NUM_AXES;
  localparam int SW = 7 + NUM_PAIRS + HW;
  localparam int STW = afs_pkg::STATUS_WIDTH;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [afs_pkg::SYNC_STAGES-1:0] rst_pipe_q;
  logic rstn;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_pipe_q <= '0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[afs_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rstn = rst_pipe_q[afs_pkg::SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  afs_sync_if #(.WIDTH(SW)) pins_if ();

  assign pins_if.raw = {late_revision_strap_in, hall_in, pair_over_20a_in,
                        temp_above_80c_in, temp_above_100c_in, supply_below_90v_in,
                        supply_above_94v_in, supply_below_18v_in, emergency_stop_input_in};

  afs_sync #(.WIDTH(SW)) u_sync (
    .clock_in(clock_in),
    .rstn_in(rstn),
    .bus(pins_if.stage)
  );

  logic estop_s;
  logic uv_s;
  logic above94_s;
  logic below90_s;
  logic t100_s;
  logic t80_s;
  logic [NUM_PAIRS-1:0] oc_s;
  logic [HW-1:0] hall_s;
  logic strap_s;

  assign estop_s = pins_if.synced[0];
  assign uv_s = pins_if.synced[1];
  assign above94_s = pins_if.synced[2];
  assign below90_s = pins_if.synced[3];
  assign t100_s = pins_if.synced[4];
  assign t80_s = pins_if.synced[5];
  assign oc_s = pins_if.synced[6 +: NUM_PAIRS];
  assign hall_s = pins_if.synced[6 + NUM_PAIRS +: HW];
  assign strap_s = pins_if.synced[SW-1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [afs_pkg::SYNC_STAGES-1:0] warm;
    logic strap_done;
    logic late_rev;
    logic estop_latch;
    logic mo_seen;
    logic motor_off;
    logic ov;
    logic [NUM_PAIRS-1:0] oc;
    logic ot_latch;
    logic [NUM_AXES-1:0] hall_prev;
    logic uv_prev;
    logic ot_prev;
    logic estop_prev;
    logic oc_prev;
    logic amp_en;
    logic relay;
    logic handler;
    logic [STW-1:0] status;
    logic status_valid;
    logic [HW-1:0] hall_state;
    logic hall_valid;
  } afs_state_t;

  afs_state_t state_q;
  afs_state_t state_d;

  logic [NUM_AXES-1:0] hall_err;
  logic [NUM_AXES-1:0] hall_off;
  logic ot_active;
  logic oc_any;
  logic fault_any;
  logic event_any;
  logic [STW-1:0] sel0;
  logic [STW-1:0] sel1;
  logic [STW-1:0] sel2;
  logic [STW-1:0] sel3;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_d = state_q;

    // revision strap is caught once, after the pin synchroniser has filled
    state_d.warm = {state_q.warm[afs_pkg::SYNC_STAGES-2:0], 1'b1};
    if (state_q.warm[afs_pkg::SYNC_STAGES-1] && !state_q.strap_done) begin
      state_d.strap_done = 1'b1;
      state_d.late_rev = strap_s;
    end

    for (int a = 0; a < NUM_AXES; a++) begin
      hall_err[a] = !brush_mode_in[a] && !phasing_60_in[a] &&
                    ((hall_s[a*afs_pkg::HALL_BITS +: afs_pkg::HALL_BITS] ==
                      afs_pkg::HALL_ALL_LOW) ||
                     (hall_s[a*afs_pkg::HALL_BITS +: afs_pkg::HALL_BITS] ==
                      afs_pkg::HALL_ALL_HIGH));
      hall_off[a] = hall_err[a] && off_on_error_in[a];
    end

    // over-voltage hysteresis, transient only
    if (above94_s) begin
      state_d.ov = 1'b1;
    end else if (below90_s) begin
      state_d.ov = 1'b0;
    end

    // recovery commands: clears first, hardware sets below win
    if (controller_reset_command_in) begin
      state_d.estop_latch = 1'b0;
      state_d.mo_seen = 1'b0;
      state_d.motor_off = 1'b0;
      state_d.oc = '0;
      state_d.ot_latch = 1'b0;
    end else begin
      if (motor_off_command_in) begin
        state_d.motor_off = 1'b1;
        state_d.mo_seen = 1'b1;
      end else if (servo_on_command_in) begin
        state_d.motor_off = 1'b0;
        state_d.mo_seen = 1'b0;
        if (state_q.mo_seen && !estop_s) begin
          state_d.estop_latch = 1'b0;
        end
        for (int p = 0; p < NUM_PAIRS; p++) begin
          if (!oc_s[p]) begin
            state_d.oc[p] = 1'b0;
          end
        end
        if (!t80_s) begin
          state_d.ot_latch = 1'b0;
        end
      end
    end

    if (estop_s) begin
      state_d.estop_latch = 1'b1;
      state_d.mo_seen = 1'b0;
    end
    // over-current latches regardless of off-on-error or handler
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (oc_s[p]) begin
        state_d.oc[p] = 1'b1;
      end
    end
    if (state_q.late_rev && t80_s) begin
      state_d.ot_latch = 1'b1;
    end
    if (|hall_off) begin
      state_d.motor_off = 1'b1;
    end

    ot_active = state_q.late_rev ? state_q.ot_latch : t100_s;
    oc_any = |state_q.oc;

    // any active fault drops the enable; hall errors only through motor-off when off-on-error is set
    fault_any = estop_s || state_q.estop_latch || state_q.motor_off || uv_s ||
                state_q.ov || oc_any || ot_active;
    state_d.amp_en = !fault_any;

    // motor-off state opens the relay when the option is fitted
    state_d.relay = !solid_state_relay_option_in ||
                    !(state_q.motor_off || state_q.estop_latch || estop_s);

    // handler events on new faults; over-voltage excluded
    state_d.uv_prev = uv_s;
    state_d.ot_prev = ot_active;
    state_d.estop_prev = estop_s;
    state_d.oc_prev = oc_any;
    state_d.hall_prev = hall_err;
    event_any = (uv_s && !state_q.uv_prev) ||
                (ot_active && !state_q.ot_prev) ||
                (estop_s && !state_q.estop_prev) ||
                (oc_any && !state_q.oc_prev) ||
                (|(hall_err & ~state_q.hall_prev));
    state_d.handler = event_any && thread0_running_in &&
                      handler_label_present_in;

    // status selectors, read-only views
    sel0 = '0;
    sel0[afs_pkg::BIT_UNDER_VOLT] = uv_s;
    sel0[afs_pkg::BIT_OVER_VOLT] = state_q.ov;
    sel0[afs_pkg::BIT_OVER_TEMP] = ot_active;
    sel0[afs_pkg::BIT_OVER_CURR +: NUM_PAIRS] = state_q.oc;
    sel1 = '0;
    sel1[NUM_AXES-1:0] = hall_err;
    sel2 = '0;
    sel2[NUM_AXES-1:0] = over_continuous_in;
    sel3 = '0;
    sel3[afs_pkg::BIT_ESTOP] = state_q.estop_latch || estop_s;

    // reads only capture data, nothing else changes
    state_d.status_valid = amp_status_query_in;
    if (amp_status_query_in) begin
      unique case (status_select_in)
        afs_pkg::SEL_SUPPLY: state_d.status = sel0;
        afs_pkg::SEL_HALL: state_d.status = sel1;
        afs_pkg::SEL_CONT_CURRENT: state_d.status = sel2;
        afs_pkg::SEL_ESTOP: state_d.status = sel3;
      endcase
    end
    state_d.hall_valid = hall_state_query_in;
    if (hall_state_query_in) begin
      state_d.hall_state = hall_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
      state_q.motor_off <= afs_pkg::RST_MOTOR_OFF;
      state_q.amp_en <= afs_pkg::RST_AMP_ENABLE;
      state_q.relay <= afs_pkg::RST_RELAY;
      state_q.status <= afs_pkg::RST_STATUS;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign amp_enable_out = state_q.amp_en;
  assign motor_off_state_out = state_q.motor_off;
  assign relay_connect_out = state_q.relay;
  assign amp_error_handler_out = state_q.handler;
  assign status_data_out = state_q.status;
  assign status_valid_out = state_q.status_valid;
  assign hall_state_out = state_q.hall_state;
  assign hall_state_valid_out = state_q.hall_valid;

endmodule : amp_fault_supervisor

// >>> testbench/afs_amp_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// supply in tenths of a volt, heatsink in degrees
module afs_amp_model (
  input wire logic [15:0] supply_dv_in,
  input wire logic [15:0] temp_c_in,
  output logic below_18v_out,
  output logic above_94v_out,
  output logic below_90v_out,
  output logic above_100c_out,
  output logic above_80c_out
);
  assign below_18v_out = supply_dv_in < 16'h00b4;
  assign above_94v_out = supply_dv_in > 16'h03ac;
  assign below_90v_out = supply_dv_in < 16'h0384;
  assign above_100c_out = temp_c_in > 16'h0064;
  assign above_80c_out = temp_c_in > 16'h0050;
endmodule : afs_amp_model

// >>> testbench/afs_chk.sv
`timescale 1ns/10ps
module afs_chk #(
  parameter int NUM_PAIRS = 2
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic emergency_stop_input_in,
  input wire logic supply_below_18v_in,
  input wire logic supply_above_94v_in,
  input wire logic [NUM_PAIRS-1:0] pair_over_20a_in,
  input wire logic solid_state_relay_option_in,
  input wire logic servo_on_command_in,
  input wire logic controller_reset_command_in,
  input wire logic thread0_running_in,
  input wire logic handler_label_present_in,
  input wire logic amp_status_query_in,
  input wire logic hall_state_query_in,
  input wire logic amp_enable_out,
  input wire logic motor_off_state_out,
  input wire logic relay_connect_out,
  input wire logic amp_error_handler_out,
  input wire logic status_valid_out,
  input wire logic hall_state_valid_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  estop_off_a: assert property (emergency_stop_input_in |-> ##[1:4] !amp_enable_out)
    else $error("enable on under stop");
  estop_handler_a: assert property ($rose(emergency_stop_input_in) && thread0_running_in
    && handler_label_present_in |-> ##[2:6] amp_error_handler_out) else $error("no handler");
  handler_gate_a: assert property (amp_error_handler_out
    |-> $past(thread0_running_in && handler_label_present_in)) else $error("handler ungated");
  status_answer_a: assert property (status_valid_out == $past(amp_status_query_in))
    else $error("status valid timing");
  hall_answer_a: assert property (hall_state_valid_out == $past(hall_state_query_in))
    else $error("hall valid timing");
  oc_latch_a: assert property ($rose(|pair_over_20a_in) ##1 (!servo_on_command_in
    && !controller_reset_command_in)[*8] |-> !amp_enable_out) else $error("overcurrent not held");
  ov_off_a: assert property (supply_above_94v_in [*5] |-> !amp_enable_out)
    else $error("enable on in overvoltage");
  uv_off_a: assert property (supply_below_18v_in [*5] |-> !amp_enable_out)
    else $error("enable on in undervoltage");
  relay_open_a: assert property ((solid_state_relay_option_in && motor_off_state_out) [*2]
    |-> !relay_connect_out) else $error("relay closed in motor-off");
  enable_clean_a: assert property (amp_enable_out |-> !$past(motor_off_state_out))
    else $error("enable with motor-off");
endmodule : afs_chk
bind amp_fault_supervisor afs_chk #(.NUM_PAIRS(NUM_PAIRS)) chk_i (.*);

// >>> testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clock_in, resetn_in, emergency_stop_input_in, late_revision_strap_in, ov_m;
  logic solid_state_relay_option_in, motor_off_command_in, servo_on_command_in;
  logic controller_reset_command_in, thread0_running_in, handler_label_present_in;
  logic amp_status_query_in, hall_state_query_in, status_valid_out, hall_state_valid_out;
  logic supply_below_18v_in, supply_above_94v_in, supply_below_90v_in;
  logic temp_above_100c_in, temp_above_80c_in;
  logic amp_enable_out, motor_off_state_out, relay_connect_out, amp_error_handler_out;
  logic [1:0] pair_over_20a_in, status_select_in;
  logic [11:0] hall_in, hall_state_out;
  logic [3:0] over_continuous_in, brush_mode_in, phasing_60_in, off_on_error_in;
  logic [7:0] status_data_out;
  logic [15:0] supply, temp;
  logic [31:0] seed, r;
  logic [15:0] sup_tab [4] = '{16'h0078, 16'h01f4, 16'h0398, 16'h03c0};
  logic [15:0] tmp_tab [4] = '{16'h0019, 16'h005a, 16'h006e, 16'h005a};
  int miscompares, check_count;
  amp_fault_supervisor dut (.*);
  afs_amp_model amp (.supply_dv_in(supply), .temp_c_in(temp),
    .below_18v_out(supply_below_18v_in), .above_94v_out(supply_above_94v_in),
    .below_90v_out(supply_below_90v_in), .above_100c_out(temp_above_100c_in),
    .above_80c_out(temp_above_80c_in));
////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function logic [11:0] hall_err();
    logic [2:0] h;
    hall_err = 12'h000;
    for (int a = 0; a < 4; a++) begin
      h = hall_in[3*a+:3];
      hall_err[a] = !brush_mode_in[a] && !phasing_60_in[a] && (h == 3'h0 || h == 3'h7);
    end
  endfunction : hall_err
  task cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cyc
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict();
    $display("mismatches %0d, checks %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task rst();
    resetn_in <= 1'b0;
    cyc(20);
    resetn_in <= 1'b1;
  endtask : rst
  task en(input logic e);
    @(negedge clock_in);
    chk(amp_enable_out, e);
    cyc(1);
  endtask : en
  task pulse(input logic [2:0] k);
    cyc(1);
    {controller_reset_command_in, motor_off_command_in, servo_on_command_in} <= k;
    cyc(1);
    {controller_reset_command_in, motor_off_command_in, servo_on_command_in} <= 3'h0;
    cyc(3);
  endtask : pulse
  task query(input logic h, input logic [1:0] s, input logic [11:0] e);
    cyc(1);
    amp_status_query_in <= !h;
    hall_state_query_in <= h;
    status_select_in <= s;
    cyc(1);
    amp_status_query_in <= 1'b0;
    hall_state_query_in <= 1'b0;
    @(negedge clock_in);
    chk(h ? hall_state_valid_out : status_valid_out, 1'b1);
    chk(h ? hall_state_out : {4'h0, status_data_out}, e);
  endtask : query
  task wait_hnd();
    for (int i = 0; i < 12; i++) begin
      @(negedge clock_in);
      if (amp_error_handler_out === 1'b1) begin
        cyc(1);
        return;
      end
    end
    chk(1'b0, 1'b1);
    give_verdict();
  endtask : wait_hnd
////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    {emergency_stop_input_in, late_revision_strap_in, solid_state_relay_option_in, ov_m,
     motor_off_command_in, servo_on_command_in, controller_reset_command_in,
     amp_status_query_in, hall_state_query_in, pair_over_20a_in, status_select_in,
     over_continuous_in, brush_mode_in, phasing_60_in, off_on_error_in, supply} = '0;
    {thread0_running_in, handler_label_present_in, resetn_in} = 3'h6;
    miscompares = 0;
    check_count = 0;
    seed = 32'hb77f;
    hall_in = 12'h249;
    temp = 16'h0019;
    rst();
    wait_hnd();
    supply <= 16'h01f4;
    pulse(3'h1);
    en(1'b1);
    repeat (12) begin
      r = rnd();
      {phasing_60_in, brush_mode_in, hall_in} <= r[19:0];
      over_continuous_in <= r[23:20];
      supply <= sup_tab[r[25:24]];
      temp <= tmp_tab[r[27:26]];
      cyc(5);
      ov_m = supply > 16'h03ac ? 1'b1 : supply < 16'h0384 ? 1'b0 : ov_m;
      query(1'b0, 2'h0, {ov_m, supply < 16'h00b4} | (temp > 16'h0064) << 2);
      query(1'b0, 2'h1, hall_err());
      query(1'b0, 2'h2, {8'h00, over_continuous_in});
      query(1'b1, 2'h0, hall_in);
      en(!(ov_m || temp > 16'h0064 || supply < 16'h00b4));
    end
    {phasing_60_in, brush_mode_in, hall_in, supply, temp} <= {20'h00249, 32'h01f40019};
    cyc(6);
    en(1'b1);
    {emergency_stop_input_in, solid_state_relay_option_in} <= 2'h3;
    wait_hnd();
    query(1'b0, 2'h3, 12'h001);
    @(negedge clock_in) chk(relay_connect_out, 1'b0);
    en(1'b0);
    emergency_stop_input_in <= 1'b0;
    pulse(3'h1);
    en(1'b0);
    pulse(3'h2);
    cyc(2);
    pulse(3'h1);
    @(negedge clock_in) chk(relay_connect_out, 1'b1);
    en(1'b1);
    {hall_in[8:6], off_on_error_in} <= 7'h7f;
    cyc(6);
    @(negedge clock_in) chk(motor_off_state_out, 1'b1);
    en(1'b0);
    hall_in[8:6] <= 3'h1;
    cyc(2);
    pulse(3'h1);
    en(1'b1);
    {thread0_running_in, pair_over_20a_in} <= 3'h2;
    cyc(6);
    pair_over_20a_in <= 2'h0;
    cyc(6);
    en(1'b0);
    query(1'b0, 2'h0, 12'h010);
    pulse(3'h1);
    en(1'b1);
    late_revision_strap_in <= 1'b1;
    rst();
    cyc(8);
    pulse(3'h1);
    en(1'b1);
    temp <= 16'h0055;
    cyc(6);
    temp <= 16'h0019;
    cyc(6);
    en(1'b0);
    pulse(3'h1);
    en(1'b1);
    pair_over_20a_in <= 2'h1;
    cyc(6);
    pair_over_20a_in <= 2'h0;
    cyc(6);
    en(1'b0);
    query(1'b0, 2'h0, 12'h008);
    pulse(3'h4);
    en(1'b1);
    query(1'b0, 2'h0, 12'h000);
    en(1'b1);
    give_verdict();
  end
endmodule : testbench
